/* subaudio_code_select_tx_control.v */
`timescale 1ns/100ps
`include "subaudio_map.vh"
//
// Contract
// - Low selector byte: none, DCS, user DCS
// - 101-184 pick inverted DCS forms
// - 200 selects tone auto-learn mode
// - 201-254 tones, 255 invalid tone
// - Tone selectors except user 252 map to fixed frequencies
// - DCS selectors except user 84/184 map to octal code words
// - Bits 9,8 give 180/120 degree shift
// - DCS 23/24 bit, true/inverse, end burst
// - Separate enables keep stored selector
// - Signalling stays below 260 Hz
// - Filter attenuates below 300 Hz
// - Modulator ramps from and to bias
// - Ramp rate setting, two ramp enables
// - Disabled sits at bias, off floats
// - Soft limit default, hard by bit 13
// - Scrambler 3300 Hz reset, live updates
// - Compressor halves dB, expandor doubles
// - Audio and sub-audio summed onto output
module subaudio_code_select_tx_control #(
    parameter EOT_CYCLES = 25000000  // End burst length in cycles
) (
    input  wire        clk,
    input  wire        rst,
    input  wire [9:0]  audio_ctrl,           // Selector and phase bits
    input  wire        ctcss_en,             // Tone signalling enable
    input  wire        dcs_en,               // Code signalling enable
    input  wire        dcs_len24,            // 24-bit code length
    input  wire        tx_mode,              // Transmit requested
    input  wire        hpf_en,               // 300 Hz high-pass enable
    input  wire [1:0]  ramp_en,              // Bit 0 up, bit 1 down
    input  wire [7:0]  ramp_rate_setting,    // Cycles per step minus one
    input  wire        mod_out_en,           // Modulator output enable
    input  wire        mod_powerdown,        // Modulator driver off
    input  wire [15:0] limiter_mode_setting, // Limiter mode word
    input  wire [15:0] limiter_level_setting,// Limiting threshold
    input  wire        scram_wr,             // Scrambler frequency strobe
    input  wire [15:0] scram_freq,           // New inversion frequency
    input  wire signed [15:0] audio_in,      // Audio band sample
    input  wire signed [15:0] subaudio_in,   // Sub-audio sample
    input  wire signed [7:0]  comp_in_db,    // Envelope level in dB
    output reg  [2:0]  sig_kind_q,           // Decoded signalling kind
    output reg  [8:0]  dcs_code_q,           // DCS code word, octal digits
    output reg         dcs_invert_q,         // Inverse modulation form
    output reg         dcs_len24_q,          // Code length select
    output reg         dcs_active_q,         // DCS coder running
    output reg         dcs_eot_burst_q,      // End-of-transmission burst
    output reg  [15:0] tone_freq_q,          // Tone frequency, BCD 0.1 Hz
    output reg         tone_user_q,          // User tone selected
    output reg         tone_active_q,        // Tone generator running
    output reg         learn_mode_q,         // Tone auto-learn mode
    output reg         invalid_tone_q,       // Invalid tone selected
    output reg  [1:0]  tone_phase_q,         // Tone phase shift code
    output reg         hpf_active_q,         // High-pass filter in path
    output reg         hard_limit_q,         // Hard limiter selected
    output reg  [15:0] limit_level_q,        // Limiting threshold
    output reg  [15:0] scram_freq_q,         // Scrambler inversion freq
    output reg  signed [7:0] comp_out_db_q,  // Compressor output dB
    output reg  signed [7:0] exp_out_db_q,   // Expandor output dB
    output reg  [15:0] modulator_output,     // Offset-binary output
    output reg         modulator_output_oe   // High while pin driven
);
    wire [7:0]  sel = audio_ctrl[7:0];       // Selector byte
    reg  [2:0]  kind_d;                      // Decoded kind
    reg  [7:0]  dcs_idx;                     // Standard code index
    reg  [11:0] dcs_digits;                  // Octal digits, one a nibble
    wire [15:0] ct_freq;                     // Fixed tone frequency
    wire [8:0]  gain;                        // Ramp gain
    reg  [31:0] eot_cnt_q;                   // End burst countdown
    reg         tx_q;                        // Previous transmit request
    // Burst starts here, a cycle before its flag, so the ramp never dips
    wire        eot_start = tx_q && !tx_mode && dcs_active_q;
    wire        dcs_sel = (kind_d == `KIND_DCS) || (kind_d == `KIND_DCS_USER);
    wire        ct_sel  = (kind_d == `KIND_CTCSS) || (kind_d == `KIND_CT_USER);

    // Selector classification
    always @* begin
        // Index follows the selector unless the inverted range remaps it
        dcs_idx = sel;
        if (sel == `SEL_NONE)
            kind_d = `KIND_NONE;
        else if (sel <= `SEL_DCS_LAST)
            kind_d = `KIND_DCS;
        else if (sel == `SEL_DCS_USER)
            kind_d = `KIND_DCS_USER;
        else if (sel >= `SEL_INV_FIRST && sel <= `SEL_INV_LAST) begin
            kind_d  = `KIND_DCS;
            dcs_idx = sel - `SEL_INV_OFFSET;
        end else if (sel == `SEL_INV_USER)
            kind_d = `KIND_DCS_USER;
        else if (sel == `SEL_LEARN)
            kind_d = `KIND_LEARN;
        else if (sel == `SEL_INVALID)
            kind_d = `KIND_INVALID;
        else if (sel == `SEL_CT_USER)
            kind_d = `KIND_CT_USER;
        // Open-ended test is safe only after 252 and 255 are taken
        else if (sel >= `SEL_CT_FIRST)
            kind_d = `KIND_CTCSS;
        else
            kind_d = `KIND_NONE;
    end

    always @*
        case (dcs_idx)
            8'h01: dcs_digits = 12'h023; 8'h02: dcs_digits = 12'h025;
            8'h03: dcs_digits = 12'h026; 8'h04: dcs_digits = 12'h031;
            8'h05: dcs_digits = 12'h032; 8'h06: dcs_digits = 12'h043;
            8'h07: dcs_digits = 12'h047; 8'h08: dcs_digits = 12'h051;
            8'h09: dcs_digits = 12'h054; 8'h0a: dcs_digits = 12'h065;
            8'h0b: dcs_digits = 12'h071; 8'h0c: dcs_digits = 12'h072;
            8'h0d: dcs_digits = 12'h073; 8'h0e: dcs_digits = 12'h074;
            8'h0f: dcs_digits = 12'h114; 8'h10: dcs_digits = 12'h115;
            8'h11: dcs_digits = 12'h116; 8'h12: dcs_digits = 12'h125;
            8'h13: dcs_digits = 12'h131; 8'h14: dcs_digits = 12'h132;
            8'h15: dcs_digits = 12'h134; 8'h16: dcs_digits = 12'h143;
            8'h17: dcs_digits = 12'h152; 8'h18: dcs_digits = 12'h155;
            8'h19: dcs_digits = 12'h156; 8'h1a: dcs_digits = 12'h162;
            8'h1b: dcs_digits = 12'h165; 8'h1c: dcs_digits = 12'h172;
            8'h1d: dcs_digits = 12'h174; 8'h1e: dcs_digits = 12'h205;
            8'h1f: dcs_digits = 12'h223; 8'h20: dcs_digits = 12'h226;
            8'h21: dcs_digits = 12'h243; 8'h22: dcs_digits = 12'h244;
            8'h23: dcs_digits = 12'h245; 8'h24: dcs_digits = 12'h251;
            8'h25: dcs_digits = 12'h261; 8'h26: dcs_digits = 12'h263;
            8'h27: dcs_digits = 12'h265; 8'h28: dcs_digits = 12'h271;
            8'h29: dcs_digits = 12'h306; 8'h2a: dcs_digits = 12'h311;
            8'h2b: dcs_digits = 12'h315; 8'h2c: dcs_digits = 12'h331;
            8'h2d: dcs_digits = 12'h343; 8'h2e: dcs_digits = 12'h346;
            8'h2f: dcs_digits = 12'h351; 8'h30: dcs_digits = 12'h364;
            8'h31: dcs_digits = 12'h365; 8'h32: dcs_digits = 12'h371;
            8'h33: dcs_digits = 12'h411; 8'h34: dcs_digits = 12'h412;
            8'h35: dcs_digits = 12'h413; 8'h36: dcs_digits = 12'h423;
            8'h37: dcs_digits = 12'h431; 8'h38: dcs_digits = 12'h432;
            8'h39: dcs_digits = 12'h445; 8'h3a: dcs_digits = 12'h464;
            8'h3b: dcs_digits = 12'h465; 8'h3c: dcs_digits = 12'h466;
            8'h3d: dcs_digits = 12'h503; 8'h3e: dcs_digits = 12'h506;
            8'h3f: dcs_digits = 12'h516; 8'h40: dcs_digits = 12'h532;
            8'h41: dcs_digits = 12'h546; 8'h42: dcs_digits = 12'h565;
            8'h43: dcs_digits = 12'h606; 8'h44: dcs_digits = 12'h612;
            8'h45: dcs_digits = 12'h624; 8'h46: dcs_digits = 12'h627;
            8'h47: dcs_digits = 12'h631; 8'h48: dcs_digits = 12'h632;
            8'h49: dcs_digits = 12'h654; 8'h4a: dcs_digits = 12'h662;
            8'h4b: dcs_digits = 12'h664; 8'h4c: dcs_digits = 12'h703;
            8'h4d: dcs_digits = 12'h712; 8'h4e: dcs_digits = 12'h723;
            8'h4f: dcs_digits = 12'h731; 8'h50: dcs_digits = 12'h732;
            8'h51: dcs_digits = 12'h734; 8'h52: dcs_digits = 12'h743;
            8'h53: dcs_digits = 12'h754;
            // User code lives elsewhere; no word here
            default: dcs_digits = 12'h000;
        endcase

    ctcss_tone_lut u_lut (
        .sel      (sel),
        .freq_bcd (ct_freq)
    );

    // Selection outputs, re-evaluated every cycle so settings act at once
    always @(posedge clk) begin
        if (rst) begin
            sig_kind_q     <= `KIND_NONE;
            dcs_code_q     <= 9'h000;
            dcs_invert_q   <= 1'b0;
            dcs_len24_q    <= 1'b0;
            dcs_active_q   <= 1'b0;
            tone_freq_q    <= 16'h0000;
            tone_user_q    <= 1'b0;
            tone_active_q  <= 1'b0;
            learn_mode_q   <= 1'b0;
            invalid_tone_q <= 1'b0;
            tone_phase_q   <= `PH_NONE;
        end else begin
            sig_kind_q     <= kind_d;
            // Each octal digit needs three bits; the spare nibble bit is dropped
            dcs_code_q     <= {dcs_digits[10:8], dcs_digits[6:4], dcs_digits[2:0]};
            dcs_invert_q   <= dcs_sel && (sel > `SEL_DCS_USER);
            dcs_len24_q    <= dcs_len24;
            dcs_active_q   <= dcs_en && dcs_sel;
            // Frequency of the user tone lives outside this block
            tone_user_q    <= (kind_d == `KIND_CT_USER);
            tone_active_q  <= ctcss_en && ct_sel && (ct_freq < `BAND_LIMIT_BCD);
            // Frequency stays visible while the enable is off
            tone_freq_q    <= ct_sel ? ct_freq : 16'h0000;
            learn_mode_q   <= ctcss_en && (kind_d == `KIND_LEARN);
            invalid_tone_q <= (kind_d == `KIND_INVALID);
            // Bit 9 wins when both shift bits are set
            // reverse burst phase shift
            if (audio_ctrl[`BIT_PH180])
                tone_phase_q <= `PH_180;
            else if (audio_ctrl[`BIT_PH120])
                tone_phase_q <= `PH_120;
            else
                tone_phase_q <= `PH_NONE;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            tx_q            <= 1'b0;
            eot_cnt_q       <= 32'h0000_0000;
            dcs_eot_burst_q <= 1'b0;
        end else begin
            tx_q <= tx_mode;
            // Falling request while the coder runs starts the burst
            if (eot_start) begin
                // Counter loads the full burst length
                eot_cnt_q       <= EOT_CYCLES;
                dcs_eot_burst_q <= 1'b1;
            end else if (eot_cnt_q != 32'h0000_0000) begin
                // A new transmission cuts the burst short
                eot_cnt_q       <= tx_mode ? 32'h0000_0000 : eot_cnt_q - 32'h0000_0001;
                dcs_eot_burst_q <= !tx_mode && (eot_cnt_q != 32'h0000_0001);
            end else begin
                dcs_eot_burst_q <= 1'b0;
            end
        end
    end

    // Ramp state is of internal use only and is left open
    // rate and enable bits steer ramp
    mod_ramp u_ramp (
        .clk     (clk),
        .rst     (rst),
        .tx_on   (tx_mode || eot_start || dcs_eot_burst_q),
        .up_en   (ramp_en[0]),
        .down_en (ramp_en[1]),
        .rate    (ramp_rate_setting),
        .gain_q  (gain),
        .state_q ()
    );

    // Summing and scaling, saturated at the edges
    // Full gain of 256 passes the sum unchanged after the shift
    wire signed [15:0] sub_gated = (tone_active_q || dcs_active_q) ? subaudio_in : 16'sh0000;
    // audio plus sub-audio onto one output
    wire signed [16:0] mix    = audio_in + sub_gated;
    wire signed [26:0] scaled = mix * $signed({1'b0, gain});
    wire signed [18:0] shr    = scaled[26:8];
    wire signed [15:0] sat    = (shr > $signed(`SAT_POS)) ? 16'sh7fff :
                                (shr < $signed(`SAT_NEG)) ? 16'sh8000 : shr[15:0];

    // zero gain means output at bias
    always @(posedge clk) begin
        if (rst) begin
            modulator_output    <= `MOD_BIAS;
            modulator_output_oe <= 1'b0;
        end else begin
            // powered down floats, disabled sits at bias
            modulator_output_oe <= !mod_powerdown;
            // Bias is also held while floating, so release is quiet
            if (mod_powerdown || !mod_out_en)
                modulator_output <= `MOD_BIAS;
            else
                // Inverting the sign bit gives offset binary
                modulator_output <= {~sat[15], sat[14:0]};
        end
    end

    // Audio path settings
    always @(posedge clk) begin
        if (rst) begin
            hpf_active_q  <= 1'b0;
            hard_limit_q  <= 1'b0;
            limit_level_q <= 16'h0000;
            scram_freq_q  <= `SCRAM_DEFAULT;
            comp_out_db_q <= 8'sh00;
            exp_out_db_q  <= 8'sh00;
        end else begin
            hpf_active_q  <= hpf_en;
            // soft unless mode bit 13 set
            hard_limit_q  <= limiter_mode_setting[`BIT_HARD_LIMIT];
            // Only registered here; the limiter itself sits downstream
            limit_level_q <= limiter_level_setting;
            // accepted in any mode, even active
            if (scram_wr)
                scram_freq_q <= scram_freq;
            // half dB out, inverse doubles
            // Arithmetic shift keeps the sign of the level
            comp_out_db_q <= comp_in_db >>> 1;
            // Doubling wraps at eight bits; levels past 63 dB alias
            exp_out_db_q  <= {comp_in_db[6:0], 1'b0};
        end
    end
endmodule // subaudio_code_select_tx_control

/* subaudio_map.vh */
`ifndef SUBAUDIO_MAP_VH
`define SUBAUDIO_MAP_VH
// Selector bounds
`define SEL_NONE        8'h00
`define SEL_DCS_LAST    8'h53
`define SEL_DCS_USER    8'h54
`define SEL_INV_FIRST   8'h65
`define SEL_INV_LAST    8'hb7
`define SEL_INV_USER    8'hb8
`define SEL_INV_OFFSET  8'h64
`define SEL_LEARN       8'hc8
`define SEL_CT_FIRST    8'hc9
`define SEL_CT_USER     8'hfc
`define SEL_CT_MAINT    8'hfd
`define SEL_CT_TURNOFF  8'hfe
`define SEL_INVALID     8'hff
// Kinds of signalling
`define KIND_NONE       3'h0
`define KIND_DCS        3'h1
`define KIND_DCS_USER   3'h2
`define KIND_CTCSS      3'h3
`define KIND_CT_USER    3'h4
`define KIND_LEARN      3'h5
`define KIND_INVALID    3'h6
// Control word bit positions
`define BIT_PH120       8
`define BIT_PH180       9
`define BIT_HARD_LIMIT  13
// Phase shift codes
`define PH_NONE         2'h0
`define PH_120          2'h1
`define PH_180          2'h2
// Frequencies, BCD tenths of hertz; scrambler default in binary hertz
`define BAND_LIMIT_BCD  16'h2600
`define MAINT_TONE_BCD  16'h0647
`define TURNOFF_BCD     16'h1344
`define SCRAM_DEFAULT   16'h0ce4
// Modulator
`define MOD_BIAS        16'h8000
`define GAIN_FULL       9'h100
`define GAIN_SHIFT      8
`define SAT_POS         19'h07fff
`define SAT_NEG         19'h78000
// Ramp states
`define RS_IDLE         2'h0
`define RS_UP           2'h1
`define RS_ON           2'h2
`define RS_DOWN         2'h3
`endif

/* ctcss_tone_lut.v */
`timescale 1ns/100ps
`include "subaudio_map.vh"
// CTCSS tone number to frequency, BCD tenths of hertz
module ctcss_tone_lut (
    input  wire [7:0]  sel,       // Selector value
    output reg  [15:0] freq_bcd   // Zero when not a fixed tone
);
    // Fixed table; BCD keeps the printed digits readable
    always @* begin
        case (sel)
            8'hc9: freq_bcd = 16'h0670;
            8'hca: freq_bcd = 16'h0719;
            8'hcb: freq_bcd = 16'h0744;
            8'hcc: freq_bcd = 16'h0770;
            8'hcd: freq_bcd = 16'h0797;
            8'hce: freq_bcd = 16'h0825;
            8'hcf: freq_bcd = 16'h0854;
            8'hd0: freq_bcd = 16'h0885;
            8'hd1: freq_bcd = 16'h0915;
            8'hd2: freq_bcd = 16'h0948;
            8'hd3: freq_bcd = 16'h0974;
            8'hd4: freq_bcd = 16'h1000;
            8'hd5: freq_bcd = 16'h1035;
            8'hd6: freq_bcd = 16'h1072;
            8'hd7: freq_bcd = 16'h1109;
            8'hd8: freq_bcd = 16'h1148;
            8'hd9: freq_bcd = 16'h1188;
            8'hda: freq_bcd = 16'h1230;
            8'hdb: freq_bcd = 16'h1273;
            8'hdc: freq_bcd = 16'h1318;
            8'hdd: freq_bcd = 16'h1365;
            8'hde: freq_bcd = 16'h1413;
            8'hdf: freq_bcd = 16'h1462;
            8'he0: freq_bcd = 16'h1514;
            8'he1: freq_bcd = 16'h1567;
            8'he2: freq_bcd = 16'h1622;
            8'he3: freq_bcd = 16'h1679;
            8'he4: freq_bcd = 16'h1738;
            8'he5: freq_bcd = 16'h1799;
            8'he6: freq_bcd = 16'h1862;
            8'he7: freq_bcd = 16'h1928;
            8'he8: freq_bcd = 16'h2035;
            8'he9: freq_bcd = 16'h2107;
            8'hea: freq_bcd = 16'h2181;
            8'heb: freq_bcd = 16'h2257;
            8'hec: freq_bcd = 16'h2336;
            8'hed: freq_bcd = 16'h2418;
            8'hee: freq_bcd = 16'h2503;
            8'hef: freq_bcd = 16'h0693;
            8'hf0: freq_bcd = 16'h0625;
            8'hf1: freq_bcd = 16'h1598;
            8'hf2: freq_bcd = 16'h1655;
            8'hf3: freq_bcd = 16'h1713;
            8'hf4: freq_bcd = 16'h1773;
            8'hf5: freq_bcd = 16'h1835;
            8'hf6: freq_bcd = 16'h1899;
            8'hf7: freq_bcd = 16'h1966;
            8'hf8: freq_bcd = 16'h1995;
            8'hf9: freq_bcd = 16'h2065;
            8'hfa: freq_bcd = 16'h2291;
            8'hfb: freq_bcd = 16'h2541;
            `SEL_CT_MAINT:   freq_bcd = `MAINT_TONE_BCD;
            `SEL_CT_TURNOFF: freq_bcd = `TURNOFF_BCD;
            // User tone and everything else carry no fixed value
            default: freq_bcd = 16'h0000;
        endcase
    end
endmodule // ctcss_tone_lut

/* mod_ramp.v */
`timescale 1ns/100ps
`include "subaudio_map.vh"
// Modulator gain ramp between bias and full level
module mod_ramp (
    input  wire       clk,
    input  wire       rst,
    input  wire       tx_on,      // Wanted: transmit at full level
    input  wire       up_en,      // Ramp up instead of jumping
    input  wire       down_en,    // Ramp down instead of jumping
    input  wire [7:0] rate,       // Cycles per gain step, minus one
    output reg  [8:0] gain_q,     // 0 = bias only, full = 256
    output reg  [1:0] state_q     // Ramp state
);
    reg [7:0] tick_q;             // Step prescaler
    wire      step = (tick_q == rate);
    // Prescaler free-runs; restart keeps step spacing even
    always @(posedge clk) begin
        if (rst || step)
            tick_q <= 8'h00;
        else
            tick_q <= tick_q + 8'h01;
    end
    // Gain walks one step per tick toward the target
    always @(posedge clk) begin
        if (rst) begin
            gain_q  <= 9'h000;
            state_q <= `RS_IDLE;
        end else begin
            case (state_q)
                `RS_IDLE: if (tx_on) state_q <= `RS_UP;
                `RS_UP: begin
                    if (!tx_on) begin
                        state_q <= `RS_DOWN;
                    end else if (!up_en || gain_q == `GAIN_FULL) begin
                        // Without ramping the level jumps
                        gain_q  <= `GAIN_FULL;
                        state_q <= `RS_ON;
                    end else if (step) begin
                        gain_q <= gain_q + 9'h001;
                    end
                end
                `RS_ON: if (!tx_on) state_q <= `RS_DOWN;
                `RS_DOWN: begin
                    if (tx_on) begin
                        state_q <= `RS_UP;
                    end else if (!down_en || gain_q == 9'h000) begin
                        gain_q  <= 9'h000;
                        state_q <= `RS_IDLE;
                    end else if (step) begin
                        gain_q <= gain_q - 9'h001;
                    end
                end
                default: state_q <= `RS_IDLE;
            endcase
        end
    end
endmodule // mod_ramp

/* subaudio_code_select_tx_control_assertions.sv */
`timescale 1ns/100ps
// Watches selector decode and modulator pin behaviour
module sel_checker (
    input wire        clk,
    input wire        rst,
    input wire [9:0]  audio_ctrl,
    input wire        ctcss_en,
    input wire        scram_wr,
    input wire [15:0] scram_freq,
    input wire        mod_out_en,
    input wire        mod_powerdown,
    input wire [2:0]  sig_kind_q,
    input wire [8:0]  dcs_code_q,
    input wire        dcs_invert_q,
    input wire        learn_mode_q,
    input wire        invalid_tone_q,
    input wire [1:0]  tone_phase_q,
    input wire [15:0] scram_freq_q,
    input wire [15:0] modulator_output,
    input wire        modulator_output_oe
);
    wire [7:0] sel = audio_ctrl[7:0]; // Selector byte
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_dcs_first_word: assert property (sel == 8'h01 |=> dcs_code_q == 9'h013)
        else $error("first code word wrong");
    a_inv_form: assert property (sel >= 8'h65 && sel <= 8'hb8 |=> dcs_invert_q)
        else $error("inverse form not flagged");
    a_learn_sel: assert property (ctcss_en && sel == 8'hc8 |=> learn_mode_q)
        else $error("learn mode missing");
    a_invalid_sel: assert property (sel == 8'hff |=> invalid_tone_q && sig_kind_q == 3'h6)
        else $error("invalid tone missing");
    a_gap_none: assert property (sel > 8'h54 && sel < 8'h65 |=> sig_kind_q == 3'h0)
        else $error("gap selector not none");
    a_phase_half: assert property (audio_ctrl[9] |=> tone_phase_q == 2'h2)
        else $error("half turn shift missing");
    a_scram_take: assert property (scram_wr |=> scram_freq_q == $past(scram_freq))
        else $error("scrambler value not taken");
    a_pd_float: assert property (mod_powerdown |=> !modulator_output_oe)
        else $error("driver not released");
    a_off_bias: assert property ((!mod_out_en || mod_powerdown) [*2] |=> modulator_output == 16'h8000)
        else $error("output not at bias");
endmodule // sel_checker
bind subaudio_code_select_tx_control sel_checker chk (.*);

/* host_model.sv */
`timescale 1ns/100ps
// Host side: loads selector, then enables signalling
module host_model (
    input wire       clk,
    output reg [9:0] audio_ctrl,
    output reg       ctcss_en,
    output reg       dcs_en,
    output reg       hpf_en
);
    initial {audio_ctrl, ctcss_en, dcs_en, hpf_en} = 13'h0;
    task load(input [9:0] w, input c, input d);
        @(negedge clk) {ctcss_en, dcs_en} = 2'h0;
        audio_ctrl = w;
        en(c, d);
    endtask
    task en(input c, input d);
        @(negedge clk) {ctcss_en, dcs_en, hpf_en} = {c, d, c | d};
    endtask
endmodule // host_model

/* subaudio_code_select_tx_control_tb.sv */
`timescale 1ns/100ps
`define CHK(a,e) begin n_checks++; if ((a) !== (e)) begin fail_count++; \
 $display("MISMATCH t=%0t got %h exp %h", $time, a, e); end end
`define WAITQ(c) begin k = 0; while (!(c) && k < 900) begin @(negedge clk); k++; end \
 if (!(c)) begin fail_count++; report_and_stop; end end
module subaudio_code_select_tx_control_tb;
    reg clk = 1'b0, rst = 1'b1, dcs_len24 = 1'b0, tx_mode = 1'b0, scram_wr = 1'b0;
    reg mod_out_en = 1'b1, mod_powerdown = 1'b0;
    reg [1:0] ramp_en = 2'h3;
    reg [7:0] ramp_rate_setting = 8'h00, comp_in_db = 8'h00;
    reg [15:0] limiter_mode_setting = 16'h0, limiter_level_setting = 16'h0, scram_freq = 16'h0;
    reg signed [15:0] audio_in = 16'sh0, subaudio_in = 16'sh0;
    wire [9:0] audio_ctrl;
    wire ctcss_en, dcs_en, hpf_en, dcs_invert_q, dcs_len24_q, dcs_active_q, dcs_eot_burst_q;
    wire tone_user_q, tone_active_q, learn_mode_q, invalid_tone_q, hpf_active_q;
    wire hard_limit_q, modulator_output_oe;
    wire [2:0] sig_kind_q;
    wire [8:0] dcs_code_q;
    wire [1:0] tone_phase_q;
    wire [15:0] tone_freq_q, limit_level_q, scram_freq_q, modulator_output;
    wire signed [7:0] comp_out_db_q, exp_out_db_q;
    int fail_count = 0, n_checks = 0, k;
    always #4 clk = ~clk; // 125 MHz
    host_model host (.clk(clk), .audio_ctrl(audio_ctrl), .ctcss_en(ctcss_en),
                     .dcs_en(dcs_en), .hpf_en(hpf_en));
    // Short end burst keeps the run brief
    subaudio_code_select_tx_control #(.EOT_CYCLES(20)) uut (.*);
    task report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task sel_case(input [9:0] w, input c, d, input [2:0] kd, input [8:0] cd,
                  input [15:0] f, input inv);
        host.load(w, c, d);
        @(negedge clk);
        `CHK(sig_kind_q, kd)
        `CHK(dcs_code_q, cd)
        `CHK(tone_freq_q, f)
        `CHK(dcs_invert_q, inv)
        `CHK(dcs_active_q, d && (kd == 3'h1 || kd == 3'h2))
        `CHK(tone_user_q, kd == 3'h4)
        `CHK(learn_mode_q, c && kd == 3'h5)
        `CHK(invalid_tone_q, kd == 3'h6)
    endtask
    task t_select;
        sel_case(10'h001, 0, 1, 3'h1, 9'h013, 16'h0, 0);
        sel_case(10'h053, 0, 1, 3'h1, 9'h1ec, 16'h0, 0);
        sel_case(10'h065, 0, 1, 3'h1, 9'h013, 16'h0, 1);
        sel_case(10'h0b7, 0, 1, 3'h1, 9'h1ec, 16'h0, 1);
        sel_case(10'h054, 0, 1, 3'h2, 9'h0, 16'h0, 0);
        sel_case(10'h0b8, 0, 1, 3'h2, 9'h0, 16'h0, 1);
        sel_case(10'h0c9, 1, 0, 3'h3, 9'h0, 16'h0670, 0);
        sel_case(10'h0ee, 1, 0, 3'h3, 9'h0, 16'h2503, 0);
        sel_case(10'h0fc, 1, 0, 3'h4, 9'h0, 16'h0, 0);
        sel_case(10'h0fd, 1, 0, 3'h3, 9'h0, 16'h0647, 0);
        sel_case(10'h0fe, 1, 0, 3'h3, 9'h0, 16'h1344, 0);
        sel_case(10'h0ff, 1, 0, 3'h6, 9'h0, 16'h0, 0);
        sel_case(10'h0c8, 1, 0, 3'h5, 9'h0, 16'h0, 0);
        sel_case(10'h064, 1, 1, 3'h0, 9'h0, 16'h0, 0);
        sel_case(10'h0c7, 1, 1, 3'h0, 9'h0, 16'h0, 0);
        sel_case(10'h000, 1, 1, 3'h0, 9'h0, 16'h0, 0);
        $display("select test done");
    endtask
    task t_enable;
        host.load(10'h0c9, 1, 0);
        host.en(0, 0);
        @(negedge clk);
        `CHK(tone_active_q, 1'b0)
        `CHK(tone_freq_q, 16'h0670)
        host.en(1, 0);
        @(negedge clk);
        `CHK(tone_active_q, 1'b1)
        `CHK(hpf_active_q, 1'b1)
        for (int i = 0; i < 4; i++) begin
            host.load({i[1:0], 8'hc9}, 1, 0);
            @(negedge clk);
            `CHK(tone_phase_q, i[1] ? 2'h2 : {1'b0, i[0]})
        end
        $display("enable and phase test done");
    endtask
    task t_misc;
        `CHK(hard_limit_q, 1'b0)
        limiter_mode_setting = 16'h2000;
        limiter_level_setting = 16'h1234;
        dcs_len24 = 1'b1;
        comp_in_db = 8'hec;
        scram_freq = 16'h0abc;
        scram_wr = 1'b1;
        @(negedge clk) scram_wr = 1'b0;
        @(negedge clk);
        `CHK(hard_limit_q, 1'b1)
        `CHK(limit_level_q, 16'h1234)
        `CHK(dcs_len24_q, 1'b1)
        `CHK(scram_freq_q, 16'h0abc)
        `CHK(comp_out_db_q, 8'hf6)
        `CHK(exp_out_db_q, 8'hd8)
        $display("settings test done");
    endtask
    task t_mod;
        host.load(10'h001, 0, 1);
        {audio_in, subaudio_in, tx_mode} = {16'h1000, 16'h0100, 1'b1};
        repeat (4) @(negedge clk);
        `CHK(modulator_output < 16'h9100, 1'b1)
        `WAITQ(modulator_output === 16'h9100)
        tx_mode = 1'b0;
        repeat (3) @(negedge clk);
        `CHK(dcs_eot_burst_q, 1'b1)
        `WAITQ(modulator_output === 16'h8000)
        `CHK(dcs_eot_burst_q, 1'b0)
        host.en(0, 0);
        {ramp_en, tx_mode} = {2'h0, 1'b1};
        repeat (4) @(negedge clk);
        `CHK(modulator_output, 16'h9000)
        {mod_out_en, scram_wr, scram_freq} = {2'b01, 16'h1f40};
        repeat (3) @(negedge clk);
        `CHK(modulator_output, 16'h8000)
        `CHK(modulator_output_oe, 1'b1)
        `CHK(scram_freq_q, 16'h1f40)
        {mod_powerdown, scram_wr} = 2'b10;
        repeat (2) @(negedge clk);
        `CHK(modulator_output_oe, 1'b0)
        $display("modulator test done");
    endtask
    initial begin
        repeat (6) @(negedge clk);
        rst = 1'b0;
        `CHK(scram_freq_q, 16'h0ce4)
        `CHK(modulator_output, 16'h8000)
        `CHK(modulator_output_oe, 1'b0)
        t_select;
        t_enable;
        t_misc;
        t_mod;
        report_and_stop;
    end
endmodule // subaudio_code_select_tx_control_tb
